// ==== hdl/bank_tracker.sv ====
// Per-bank open-row flags updated by accepted activate and precharge commands
`timescale 1ns/1ps
module bank_tracker #(
    parameter int BANKS = pd_cmd_pkg::NUM_BANKS
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic activate_in,
    input wire logic precharge_in,
    input wire logic precharge_all_in,
    input wire logic [pd_cmd_pkg::BANK_ADDR_W-1:0] bank_in,
    output logic [BANKS-1:0] open_out
);
    import pd_cmd_pkg::*;

    logic [BANKS-1:0] open_r;
    logic [BANKS-1:0] open_nxt;

    // Precharge-all clears every bank; single commands touch one bank only
    always_comb begin
        open_nxt = open_r;
        if (precharge_all_in) begin
            open_nxt = '0;
        end else if (precharge_in) begin
            open_nxt[bank_in] = 1'b0;
        end else if (activate_in) begin
            open_nxt[bank_in] = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            open_r <= BANKS'(BANK_OPEN_RST);
        end else begin
            open_r <= open_nxt;
        end
    end

    assign open_out = open_r;
endmodule : bank_tracker

// ==== hdl/pd_cmd_decode.sv ====
// Command decoder and power-down state machine of the memory device
//
// Function
// RQ1: Power down with all banks idle is precharge type, otherwise active type.
// RQ2: Any power down switches input and output buffers off; clock, ODT, CKE stay.
// RQ3: DLL off in precharge and slow active power down, on in fast active.
// RQ4: Controller holds CKE low, clock stable and ODT valid while powered down.
// RQ5: Controller keeps CKE low for the minimum pulse time after entry.
// RQ6: Controller limits each power-down stay to nine average refresh intervals.
// RQ7: Exit on edge where CKE samples high; controller sends NOP or deselect.
// RQ8: Controller keeps CKE high for the minimum pulse time after exit.
// RQ9: Controller waits the applicable exit latency before an executable command.
// RQ10: Frequency change only in precharge power down, ODT off, two clocks later.
// RQ11: During frequency change ODT and CKE stay low, frequency within grade.
// RQ12: New clock stable before exit, then DLL reset and mode reprogramming.
// RQ13: ODT stays off during DLL relock after a frequency change.
// RQ14: Commands decode from CS, RAS, CAS, WE and CKE sampled each rising edge.
// RQ15: Bank bits select target bank, or the mode register for mode set.
// RQ16: Bursts of four always run to completion and are never interrupted.
// RQ17: Self-refresh exit follows CKE high without needing a particular command.
// RQ18: No refresh is performed while in power down.
// RQ19: Power down entered when CKE samples low with NOP or deselect.
// RQ20: Controller never drops CKE during mode set, read or write.
// RQ21: Controller holds each CKE level for three sampled edges.
// RQ22: Self-refresh entry is accepted only when all banks are idle.
// RQ23: Open-row status is tracked so power-down type is known at CKE fall.
`timescale 1ns/1ps
module pd_cmd_decode (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire pd_cmd_pkg::cmd_pins_t pins_in,
    input wire logic slow_exit_in,
    output pd_cmd_pkg::cmd_t cmd_out,
    output logic cmd_valid_out,
    output logic [pd_cmd_pkg::BANK_ADDR_W-1:0] bank_out,
    output logic [pd_cmd_pkg::BANK_ADDR_W-1:0] mode_reg_sel_out,
    output logic mode_write_out,
    output pd_cmd_pkg::pd_state_t pd_state_out,
    output logic buffers_on_out,
    output logic dll_on_out,
    output logic refresh_run_out,
    output logic burst_busy_out,
    output logic illegal_out,
    output logic [pd_cmd_pkg::NUM_BANKS-1:0] bank_open_out
);
    import pd_cmd_pkg::*;

    // Raw command decode on the strobes and a10; CKE is handled by the state machine
    function automatic cmd_t decode_cmd(input cmd_pins_t p);
        cmd_t c;
        c = CMD_RESERVED;
        if (p.cs_n) begin
            c = CMD_DESELECT;
        end else begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h7: c = CMD_NOP;
                3'h3: c = CMD_ACTIVATE;
                3'h2: c = p.a10 ? CMD_PRECHARGE_ALL : CMD_PRECHARGE;
                3'h4: c = CMD_WRITE;
                3'h5: c = CMD_READ;
                3'h1: c = CMD_REFRESH;
                3'h0: c = CMD_MODE_SET;
                default: c = CMD_RESERVED;
            endcase
        end
        return c;
    endfunction : decode_cmd

    function automatic logic is_pd_state(input pd_state_t s);
        return s == ST_PRECHARGE_PD || s == ST_ACTIVE_PD_FAST || s == ST_ACTIVE_PD_SLOW;
    endfunction : is_pd_state

    cmd_pins_t sync1_r;
    cmd_pins_t sync2_r;
    logic cke_prev_r;
    pd_state_t state_r;
    pd_state_t state_nxt;
    logic [1:0] burst_r;
    logic [1:0] burst_nxt;
    cmd_t cmd_r;
    cmd_t cmd_nxt;
    logic valid_r;
    logic valid_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic [BANK_ADDR_W-1:0] bank_r;
    logic buffers_r;
    logic dll_r;
    logic refresh_r;
    logic mode_write_r;
    logic busy_r;
    logic [NUM_BANKS-1:0] open_w;
    logic any_open;
    cmd_t cmd_now;
    logic idle_cmd;
    logic cke_fall;
    logic cke_rise;
    logic cke_high;

    // Pins are asynchronous to the core clock, so two flops before any decode
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sync1_r <= PINS_RST;
            sync2_r <= PINS_RST;
            cke_prev_r <= 1'b0;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            cke_prev_r <= sync2_r.cke;
        end
    end

    // All strobes and CKE taken from the same sampled edge
    assign cmd_now = decode_cmd(sync2_r); // RQ14
    assign idle_cmd = cmd_now == CMD_NOP || cmd_now == CMD_DESELECT;
    assign cke_fall = cke_prev_r && !sync2_r.cke;
    assign cke_rise = !cke_prev_r && sync2_r.cke;
    assign cke_high = cke_prev_r && sync2_r.cke;
    assign any_open = |open_w; // RQ23

    // Power-down state, burst guard and command acceptance
    always_comb begin
        state_nxt = state_r;
        burst_nxt = (burst_r != 2'h0) ? burst_r - 2'h1 : burst_r;
        cmd_nxt = cmd_now;
        valid_nxt = 1'b0;
        illegal_nxt = 1'b0;
        case (state_r)
            ST_NORMAL: begin
                if (cke_fall) begin
                    if (idle_cmd && burst_r == 2'h0) begin
                        if (!any_open) begin
                            state_nxt = ST_PRECHARGE_PD; // RQ1 RQ19
                        end else if (slow_exit_in) begin
                            state_nxt = ST_ACTIVE_PD_SLOW; // RQ1
                        end else begin
                            state_nxt = ST_ACTIVE_PD_FAST; // RQ1
                        end
                    end else if (cmd_now == CMD_REFRESH && !any_open && burst_r == 2'h0) begin
                        state_nxt = ST_SELF_REFRESH; // RQ22
                    end else begin
                        illegal_nxt = 1'b1; // RQ20 RQ22
                    end
                end else if (cke_high && !idle_cmd) begin
                    valid_nxt = 1'b1;
                    case (cmd_now)
                        CMD_READ, CMD_WRITE: begin
                            // A burst of four cannot be cut short by a new column command
                            if (burst_r != 2'h0 || !open_w[sync2_r.ba]) begin
                                illegal_nxt = 1'b1; // RQ16
                                valid_nxt = 1'b0;
                            end else begin
                                burst_nxt = BURST_CYCLES; // RQ16
                            end
                        end
                        CMD_ACTIVATE: begin
                            illegal_nxt = open_w[sync2_r.ba];
                            valid_nxt = !open_w[sync2_r.ba];
                        end
                        CMD_REFRESH, CMD_MODE_SET: begin
                            illegal_nxt = any_open;
                            valid_nxt = !any_open;
                        end
                        CMD_RESERVED: begin
                            illegal_nxt = 1'b1;
                            valid_nxt = 1'b0;
                        end
                        default: begin
                            valid_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_PRECHARGE_PD, ST_ACTIVE_PD_FAST, ST_ACTIVE_PD_SLOW: begin
                if (cke_rise) begin
                    if (idle_cmd) begin
                        state_nxt = ST_NORMAL; // RQ7
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
            end
            ST_SELF_REFRESH: begin
                // Exit is not tied to a command on the sampled edge
                if (sync2_r.cke) begin
                    state_nxt = ST_NORMAL; // RQ17
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_r <= PD_STATE_RST;
            burst_r <= BURST_CNT_RST;
            cmd_r <= CMD_DESELECT;
            valid_r <= 1'b0;
            illegal_r <= 1'b0;
            bank_r <= '0;
            buffers_r <= 1'b1;
            dll_r <= 1'b1;
            refresh_r <= 1'b0;
            mode_write_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            burst_r <= burst_nxt;
            cmd_r <= cmd_nxt;
            valid_r <= valid_nxt;
            illegal_r <= illegal_nxt;
            bank_r <= sync2_r.ba; // RQ15
            buffers_r <= state_nxt == ST_NORMAL; // RQ2
            dll_r <= state_nxt == ST_NORMAL || state_nxt == ST_ACTIVE_PD_FAST; // RQ3
            // Internal refresh runs only in self refresh, never in power down
            refresh_r <= state_nxt == ST_SELF_REFRESH; // RQ18
            // Registered here so the pins see no decode glitches
            mode_write_r <= valid_nxt && cmd_nxt == CMD_MODE_SET; // RQ15
            busy_r <= burst_nxt != 2'h0; // RQ16
        end
    end

    // Open rows updated only by commands that were accepted
    bank_tracker #(.BANKS(NUM_BANKS)) u_banks (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .activate_in(valid_nxt && cmd_now == CMD_ACTIVATE),
        .precharge_in(valid_nxt && cmd_now == CMD_PRECHARGE),
        .precharge_all_in(valid_nxt && cmd_now == CMD_PRECHARGE_ALL),
        .bank_in(sync2_r.ba),
        .open_out(open_w)
    );

    assign cmd_out = cmd_r;
    assign cmd_valid_out = valid_r;
    assign bank_out = bank_r;
    assign mode_reg_sel_out = bank_r; // RQ15
    assign mode_write_out = mode_write_r;
    assign pd_state_out = state_r;
    assign buffers_on_out = buffers_r;
    assign dll_on_out = dll_r;
    assign refresh_run_out = refresh_r;
    assign burst_busy_out = busy_r;
    assign illegal_out = illegal_r;
    assign bank_open_out = open_w;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_pd_entry;
        state_r == ST_NORMAL && cke_fall && idle_cmd && burst_r == 2'h0;
    endsequence
    sequence s_col_accept;
        state_r == ST_NORMAL && cke_high && (cmd_now == CMD_READ || cmd_now == CMD_WRITE)
            && burst_r == 2'h0 && open_w[sync2_r.ba];
    endsequence

    property p_pd_entry;
        s_pd_entry |=> is_pd_state(state_r) && !buffers_on_out;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power down not entered"); // RQ19
    property p_pd_precharge;
        s_pd_entry ##0 !any_open |=> pd_state_out == ST_PRECHARGE_PD && !dll_on_out;
    endproperty
    a_pd_precharge: assert property (p_pd_precharge) else $error("wrong idle pd type"); // RQ1
    property p_pd_active;
        s_pd_entry ##0 any_open |=> pd_state_out == ($past(slow_exit_in) ? ST_ACTIVE_PD_SLOW
                                                     : ST_ACTIVE_PD_FAST);
    endproperty
    a_pd_active: assert property (p_pd_active) else $error("wrong active pd type"); // RQ1
    property p_buffers;
        is_pd_state(state_r) |-> !buffers_on_out;
    endproperty
    a_buffers: assert property (p_buffers) else $error("buffers on in pd"); // RQ2
    property p_dll;
        (state_r == ST_ACTIVE_PD_FAST |-> dll_on_out)
            and ((state_r == ST_PRECHARGE_PD || state_r == ST_ACTIVE_PD_SLOW) |-> !dll_on_out);
    endproperty
    a_dll: assert property (p_dll) else $error("dll state wrong"); // RQ3
    property p_pd_exit;
        is_pd_state(state_r) && cke_rise && idle_cmd |=> state_r == ST_NORMAL && buffers_on_out;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power down exit missed"); // RQ7
    property p_burst;
        s_col_accept |=> burst_busy_out [*2] ##1 !burst_busy_out;
    endproperty
    a_burst: assert property (p_burst) else $error("burst not two clocks"); // RQ16
    property p_burst_no_cut;
        burst_busy_out && cke_high && cmd_now == CMD_READ |=> illegal_out && !cmd_valid_out;
    endproperty
    a_burst_no_cut: assert property (p_burst_no_cut) else $error("burst interrupted"); // RQ16
    property p_sref_exit;
        state_r == ST_SELF_REFRESH && sync2_r.cke |=> state_r == ST_NORMAL;
    endproperty
    a_sref_exit: assert property (p_sref_exit) else $error("self refresh exit missed"); // RQ17
    property p_sref_guard;
        state_r == ST_NORMAL && cke_fall && cmd_now == CMD_REFRESH && any_open
            |=> illegal_out && state_r == ST_NORMAL;
    endproperty
    a_sref_guard: assert property (p_sref_guard) else $error("sref with open bank"); // RQ22
    property p_no_refresh;
        is_pd_state(state_r) |-> !refresh_run_out;
    endproperty
    a_no_refresh: assert property (p_no_refresh) else $error("refresh in power down"); // RQ18
    property p_bank;
        cmd_valid_out |-> bank_out == $past(sync2_r.ba) && cmd_out == $past(cmd_now);
    endproperty
    a_bank: assert property (p_bank) else $error("bank or command mismatch"); // RQ14 RQ15
endmodule : pd_cmd_decode

// ==== inc/pd_cmd_pkg.sv ====
// Shared constants, types and pin bundle for the power-down and command decode block
package pd_cmd_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int BANK_ADDR_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int BURST_LENGTH = 4;
    // Two data beats per clock, so a burst of four occupies two clocks
    localparam logic [1:0] BURST_CYCLES = 2'(BURST_LENGTH / 2);
    localparam logic [1:0] BURST_CNT_RST = 2'h0;
    localparam logic [3:0] BANK_OPEN_RST = 4'h0;

    typedef enum logic [3:0] {
        CMD_DESELECT = 4'h0,
        CMD_NOP = 4'h1,
        CMD_ACTIVATE = 4'h2,
        CMD_PRECHARGE = 4'h3,
        CMD_PRECHARGE_ALL = 4'h4,
        CMD_WRITE = 4'h5,
        CMD_READ = 4'h6,
        CMD_REFRESH = 4'h7,
        CMD_MODE_SET = 4'h8,
        CMD_RESERVED = 4'h9
    } cmd_t;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_PRECHARGE_PD = 3'h1,
        ST_ACTIVE_PD_FAST = 3'h2,
        ST_ACTIVE_PD_SLOW = 3'h3,
        ST_SELF_REFRESH = 3'h4
    } pd_state_t;

    localparam pd_state_t PD_STATE_RST = ST_NORMAL;

    // Control pins sampled together at each rising edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic a10;
        logic [BANK_ADDR_W-1:0] ba;
    } cmd_pins_t;

    localparam cmd_pins_t PINS_RST = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                       cke: 1'b0, a10: 1'b0, ba: 2'h0};
endpackage : pd_cmd_pkg

// ==== test/ctrl_model.sv ====
// Controller-side model that drives the device pins with legal clock-enable timing
`timescale 1ns/1ps
module ctrl_model #(
    parameter int EXIT_LAT = 3
) (
    input wire logic mclk_in,
    output pd_cmd_pkg::cmd_pins_t pins_out
);
    import pd_cmd_pkg::*;

    int held = 0;
    int junk = 0;

    // Clock enable starts high so the first commands after reset are taken
    initial begin
        pins_out = PINS_RST;
        pins_out.cke = 1'b1;
    end

    // Strobe pattern for each command; a10 picks precharge-all
    function automatic cmd_pins_t enc(input cmd_t c, input logic [1:0] ba, input logic cke);
        cmd_pins_t p;
        p = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: cke, a10: 1'b0, ba: ba};
        case (c)
            CMD_DESELECT: p.cs_n = 1'b1;
            CMD_ACTIVATE: p.ras_n = 1'b0;
            CMD_PRECHARGE: {p.ras_n, p.we_n} = 2'h0;
            CMD_PRECHARGE_ALL: {p.ras_n, p.we_n, p.a10} = 3'h1;
            CMD_WRITE: {p.cas_n, p.we_n} = 2'h0;
            CMD_READ: p.cas_n = 1'b0;
            CMD_REFRESH: {p.ras_n, p.cas_n} = 2'h0;
            CMD_MODE_SET: {p.ras_n, p.cas_n, p.we_n} = 3'h0;
            CMD_RESERVED: p.we_n = 1'b0;
            default: p.cs_n = 1'b0;
        endcase
        return p;
    endfunction : enc

    // One pin sample with no guard; used directly only for deliberate faults
    task automatic drive(input cmd_pins_t p);
        @(posedge mclk_in);
        #1;
        if (p.cke !== pins_out.cke) begin
            held = 0;
        end
        pins_out = p;
        held++;
    endtask : drive

    // Idle cycles; once powered down only clock enable matters, so others wander
    task automatic idle(input int n);
        cmd_pins_t p;
        repeat (n) begin
            p = enc(CMD_NOP, 2'h0, pins_out.cke);
            if (!pins_out.cke && held >= 3) begin
                {p.ras_n, p.cas_n, p.we_n, p.ba} = 5'(junk);
                junk++;
            end
            drive(p);
        end
    endtask : idle

    // Legal command: waits out exit latency and three-edge hold, then returns to NOP
    task automatic cmd(input cmd_t c, input logic [1:0] ba, input logic cke);
        while (held < EXIT_LAT || (cke !== pins_out.cke && held < 3)) begin
            drive(enc(CMD_NOP, 2'h0, pins_out.cke));
        end
        drive(enc(c, ba, cke));
        drive(enc(CMD_NOP, 2'h0, cke));
    endtask : cmd
endmodule : ctrl_model

// ==== test/tb.sv ====
// Self-checking testbench for the command decoder and power-down machine
`timescale 1ns/1ps
module tb;
    import pd_cmd_pkg::*;

    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic slow_exit_in = 1'b0;
    real half_ns = 10.0;
    cmd_pins_t pins;
    cmd_t cmd_out;
    pd_state_t pd_state_out;
    logic cmd_valid_out, mode_write_out, buffers_on_out, dll_on_out;
    logic refresh_run_out, burst_busy_out, illegal_out;
    logic [1:0] bank_out, mode_reg_sel_out;
    logic [3:0] bank_open_out;
    int errors = 0;
    int n_tests = 0;

    // Half-period is a variable so the clock can be retuned in power down
    always #(half_ns) mclk_in = ~mclk_in;

    ctrl_model u_ctrl (.mclk_in(mclk_in), .pins_out(pins));

    pd_cmd_decode u_dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .pins_in(pins), .slow_exit_in(slow_exit_in),
        .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out), .bank_out(bank_out),
        .mode_reg_sel_out(mode_reg_sel_out), .mode_write_out(mode_write_out),
        .pd_state_out(pd_state_out), .buffers_on_out(buffers_on_out), .dll_on_out(dll_on_out),
        .refresh_run_out(refresh_run_out), .burst_busy_out(burst_busy_out),
        .illegal_out(illegal_out), .bank_open_out(bank_open_out)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Answer lands two edges after the pin sample; cmd's trailing NOP used one edge
    task automatic settle();
        repeat (2) @(posedge mclk_in);
        #1;
    endtask : settle

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic s_reset();
        chk("state", ST_NORMAL, pd_state_out);
        chk("buffers", 8'h01, buffers_on_out);
        chk("dll", 8'h01, dll_on_out);
        chk("refresh", 8'h00, refresh_run_out);
        chk("banks", 8'h00, bank_open_out);
    endtask : s_reset

    // Activate, a write, then two reads one cycle apart: the second must be refused
    task automatic s_burst();
        u_ctrl.cmd(CMD_ACTIVATE, 2'h1, 1'b1);
        settle();
        chk("act valid", 8'h01, cmd_valid_out);
        chk("act code", CMD_ACTIVATE, cmd_out);
        chk("act bank", 8'h02, bank_open_out);
        u_ctrl.cmd(CMD_WRITE, 2'h1, 1'b1);
        settle();
        chk("wr code", CMD_WRITE, cmd_out);
        chk("wr bank", 8'h01, bank_out);
        u_ctrl.idle(2);
        u_ctrl.drive(u_ctrl.enc(CMD_READ, 2'h1, 1'b1));
        u_ctrl.drive(u_ctrl.enc(CMD_READ, 2'h1, 1'b1));
        u_ctrl.drive(u_ctrl.enc(CMD_NOP, 2'h0, 1'b1));
        @(posedge mclk_in);
        #1;
        chk("rd code", CMD_READ, cmd_out);
        chk("rd valid", 8'h01, cmd_valid_out);
        chk("rd busy", 8'h01, burst_busy_out);
        @(posedge mclk_in);
        #1;
        chk("rd busy 2", 8'h01, burst_busy_out);
        chk("rd refused", 8'h01, illegal_out);
        @(posedge mclk_in);
        #1;
        chk("rd done", 8'h00, burst_busy_out);
        u_ctrl.idle(2);
    endtask : s_burst

    // Power down with a row open: fast or slow exit picks the loop state
    task automatic s_active_pd(input logic slow);
        slow_exit_in = slow;
        u_ctrl.cmd(CMD_NOP, 2'h0, 1'b0);
        settle();
        chk("apd state", slow ? ST_ACTIVE_PD_SLOW : ST_ACTIVE_PD_FAST, pd_state_out);
        chk("apd buffers", 8'h00, buffers_on_out);
        chk("apd dll", {7'h00, !slow}, dll_on_out);
        chk("apd refresh", 8'h00, refresh_run_out);
        u_ctrl.idle(5);
        u_ctrl.cmd(CMD_NOP, 2'h0, 1'b1);
        settle();
        chk("apd exit", ST_NORMAL, pd_state_out);
        chk("apd dll on", 8'h01, dll_on_out);
    endtask : s_active_pd

    // Precharge power down with a clock retune, deselect exit, then mode set
    task automatic s_pre_pd();
        u_ctrl.cmd(CMD_PRECHARGE_ALL, 2'h0, 1'b1);
        settle();
        chk("prea banks", 8'h00, bank_open_out);
        u_ctrl.cmd(CMD_NOP, 2'h0, 1'b0);
        settle();
        chk("ppd state", ST_PRECHARGE_PD, pd_state_out);
        chk("ppd dll", 8'h00, dll_on_out);
        chk("ppd buffers", 8'h00, buffers_on_out);
        u_ctrl.idle(2);
        half_ns = 15.0;
        u_ctrl.idle(4);
        half_ns = 10.0;
        u_ctrl.idle(4);
        u_ctrl.cmd(CMD_DESELECT, 2'h0, 1'b1);
        settle();
        chk("ppd exit", ST_NORMAL, pd_state_out);
        u_ctrl.cmd(CMD_MODE_SET, 2'h2, 1'b1);
        settle();
        chk("mrs write", 8'h01, mode_write_out);
        chk("mrs select", 8'h02, mode_reg_sel_out);
    endtask : s_pre_pd

    // Refresh refused with a row open; self refresh once all banks are idle
    task automatic s_self_ref();
        u_ctrl.cmd(CMD_ACTIVATE, 2'h0, 1'b1);
        u_ctrl.cmd(CMD_REFRESH, 2'h0, 1'b1);
        settle();
        chk("ref refused", 8'h01, illegal_out);
        chk("ref invalid", 8'h00, cmd_valid_out);
        u_ctrl.cmd(CMD_PRECHARGE, 2'h0, 1'b1);
        u_ctrl.cmd(CMD_REFRESH, 2'h0, 1'b1);
        settle();
        chk("aref code", CMD_REFRESH, cmd_out);
        chk("pre banks", 8'h00, bank_open_out);
        u_ctrl.cmd(CMD_REFRESH, 2'h0, 1'b0);
        settle();
        chk("sref state", ST_SELF_REFRESH, pd_state_out);
        chk("sref run", 8'h01, refresh_run_out);
        u_ctrl.idle(5);
        u_ctrl.cmd(CMD_NOP, 2'h0, 1'b1);
        settle();
        chk("sref exit", ST_NORMAL, pd_state_out);
        chk("sref stop", 8'h00, refresh_run_out);
    endtask : s_self_ref

    // Refusals: closed-bank read, repeated activate, reserved code, self refresh with a row open
    task automatic s_refuse();
        u_ctrl.cmd(CMD_READ, 2'h0, 1'b1);
        settle();
        chk("rd closed", 8'h01, illegal_out);
        chk("rd closed busy", 8'h00, burst_busy_out);
        u_ctrl.cmd(CMD_ACTIVATE, 2'h2, 1'b1);
        u_ctrl.cmd(CMD_ACTIVATE, 2'h2, 1'b1);
        settle();
        chk("act twice", 8'h01, illegal_out);
        chk("act twice banks", 8'h04, bank_open_out);
        u_ctrl.cmd(CMD_RESERVED, 2'h0, 1'b1);
        settle();
        chk("reserved", 8'h01, illegal_out);
        chk("reserved valid", 8'h00, cmd_valid_out);
        u_ctrl.cmd(CMD_REFRESH, 2'h0, 1'b0);
        settle();
        chk("sref open", 8'h01, illegal_out);
        chk("sref open state", ST_NORMAL, pd_state_out);
        u_ctrl.cmd(CMD_NOP, 2'h0, 1'b1);
        u_ctrl.cmd(CMD_PRECHARGE_ALL, 2'h0, 1'b1);
        settle();
        chk("prea end", 8'h00, bank_open_out);
    endtask : s_refuse

    // Watchdog so a hung scenario still reaches the verdict
    initial begin
        #200000;
        errors++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        #1;
        reset_in = 1'b0;
        s_reset();
        s_burst();
        s_active_pd(1'b0);
        s_active_pd(1'b1);
        s_pre_pd();
        s_self_ref();
        s_refuse();
        test_done();
    end
endmodule : tb
